// File: design/cbtc_pkg.sv
package cbtc_pkg;
  localparam int NBUF   = 32;
  localparam int NTX    = 8;
  localparam int NMASK  = 3;
  localparam int MEM_AW = 16;
  localparam int ADDR_W = 8;

  // Register byte offsets, one aligned word each
  localparam logic [7:0] A_MASK0  = 8'h00;
  localparam logic [7:0] A_FUL_LO = 8'h0c;
  localparam logic [7:0] A_FUL_HI = 8'h10;
  localparam logic [7:0] A_OVF_LO = 8'h14;
  localparam logic [7:0] A_OVF_HI = 8'h18;
  localparam logic [7:0] A_CTL0   = 8'h1c;
  localparam logic [7:0] A_BASE   = 8'h2c;

  localparam logic [15:0] RST_16 = 16'h0000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [1:0]  MSEL_RSVD   = 2'h3;

  // Message buffer word layout
  localparam logic [2:0] WORD0     = 3'h0;
  localparam logic [2:0] WORD7     = 3'h7;
  localparam int         W0_SID_LO = 2;
  localparam int         W0_SID_HI = 12;
  localparam int         W0_SRR    = 1;
  localparam int         W0_IDE    = 0;
  localparam int         W7_FIL_LO = 8;

  typedef struct packed {
    logic       txen;
    logic       abt;
    logic       larb;
    logic       err;
    logic       req;
    logic       rtren;
    logic [1:0] pri;
  } cbtc_ctl_t;

  typedef struct packed {
    logic [2:0]  buf_id;
    logic [10:0] sid;
    logic        ext;
    logic        rtr;
  } cbtc_txhdr_t;

  typedef enum {ST_IDLE, ST_FETCH, ST_WAIT, ST_BUSY} cbtc_state_t;

  function automatic logic [MEM_AW-1:0] buf_addr(input logic [MEM_AW-1:0] base,
                                                 input logic [4:0] b, input logic [2:0] w);
    return base + MEM_AW'({b, w});
  endfunction
endpackage

// File: design/cbtc_top.sv
`timescale 1ns/1ps
module cbtc_top
  import cbtc_pkg::*;
(
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic                    awvalid,
  output wire logic                    awready,
  input  wire logic [cbtc_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                    wvalid,
  output wire logic                    wready,
  input  wire logic [31:0]             wdata,
  input  wire logic [3:0]              wstrb,
  output wire logic                    bvalid,
  input  wire logic                    bready,
  output wire logic [1:0]              bresp,
  input  wire logic                    arvalid,
  output wire logic                    arready,
  input  wire logic [cbtc_pkg::ADDR_W-1:0] araddr,
  output wire logic                    rvalid,
  input  wire logic                    rready,
  output wire logic [31:0]             rdata,
  output wire logic [1:0]              rresp,
  input  wire logic                    rx_store_valid,
  input  wire logic [4:0]              rx_store_buf,
  input  wire logic [4:0]              rx_store_filter,
  input  wire logic                    rtr_rx_valid,
  input  wire logic [2:0]              rtr_rx_buf,
  input  wire logic                    tx_ok,
  input  wire logic                    tx_lost_arb,
  input  wire logic                    tx_bus_err,
  input  wire logic                    tx_aborted,
  output wire logic                    tx_start,
  output wire cbtc_pkg::cbtc_txhdr_t   tx_hdr,
  output wire logic                    tx_abort_req,
  output wire logic [cbtc_pkg::NTX-1:0] buf_is_tx,
  input  wire logic [1:0]              acc_mask_sel,
  input  wire logic [15:0]             acc_msg_eid,
  input  wire logic [15:0]             acc_filt_eid,
  output wire logic                    acc_eid_match,
  output wire logic [cbtc_pkg::MEM_AW-1:0] mem_addr,
  output wire logic                    mem_rd,
  output wire logic                    mem_wr,
  output wire logic [15:0]             mem_wdata,
  input  wire logic [15:0]             mem_rdata
);
  import cbtc_pkg::*;

  function automatic logic [4:0] dec(input logic [ADDR_W-1:0] a);
    return {(a[1:0] == 2'h0) && (a <= A_BASE), a[5:2]};
  endfunction

  function automatic logic [3:0] pick_tx(input cbtc_ctl_t c [NTX]);
    logic       f;
    logic [2:0] idx;
    logic [1:0] bp;
    f   = 1'b0;
    idx = 3'h0;
    bp  = 2'h0;
    for (int i = 0; i < NTX; i++) begin
      if (c[i].txen && c[i].req && (!f || c[i].pri >= bp)) begin
        f   = 1'b1;
        idx = 3'(i);
        bp  = c[i].pri;
      end
    end
    return {f, idx};
  endfunction

  logic                   aw_full_reg, w_full_reg, bvalid_reg, rvalid_reg;
  logic [ADDR_W-1:0]      aw_addr_reg;
  logic [15:0]            w_data_reg;
  logic [1:0]             w_strb_reg;
  logic [1:0]             bresp_reg, rresp_reg;
  logic [31:0]            rdata_reg;
  logic [15:0]            mask_reg [NMASK];
  logic [NBUF-1:0]        full_reg, ovf_reg, full_next, ovf_next;
  logic [MEM_AW-1:0]      base_reg, mem_addr_reg;
  cbtc_ctl_t              ctl_reg [NTX];
  cbtc_ctl_t              ctl_next [NTX];
  cbtc_state_t            state_reg;
  logic [2:0]             act_reg;
  logic                   tx_start_reg, abort_reg, abort_next, cancel;
  logic                   mem_rd_reg, mem_wr_reg, match_reg;
  logic [15:0]            mem_wdata_reg;
  cbtc_txhdr_t            hdr_reg;
  logic                   wr_en, rx_acc, go, ctl_wr;
  logic [4:0]             wdec, rdec;
  logic [1:0]             ctl_pair;
  logic [15:0]            wmask, clr16;
  logic [3:0]             pk;

  assign awready   = !aw_full_reg;
  assign wready    = !w_full_reg;
  assign bvalid    = bvalid_reg;
  assign bresp     = bresp_reg;
  assign arready   = !rvalid_reg;
  assign rvalid    = rvalid_reg;
  assign rdata     = rdata_reg;
  assign rresp     = rresp_reg;
  assign tx_start  = tx_start_reg;
  assign tx_hdr    = hdr_reg;
  assign tx_abort_req  = abort_reg;
  assign acc_eid_match = match_reg;
  assign mem_addr  = mem_addr_reg;
  assign mem_rd    = mem_rd_reg;
  assign mem_wr    = mem_wr_reg;
  assign mem_wdata = mem_wdata_reg;

  assign wr_en    = aw_full_reg && w_full_reg && !bvalid_reg;
  assign wdec     = dec(aw_addr_reg);
  assign ctl_wr   = wr_en && wdec[4] && wdec[3:0] >= A_CTL0[5:2] && wdec[3:0] < A_BASE[5:2];
  assign ctl_pair = 2'(wdec[3:0] - A_CTL0[5:2]);
  assign wmask    = {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  assign clr16    = wmask & ~w_data_reg;
  assign rdec     = dec(araddr);
  // Stores into a buffer set up for sending are ignored
  assign rx_acc   = rx_store_valid && !(rx_store_buf < 5'(NTX) && ctl_reg[rx_store_buf[2:0]].txen);
  assign pk       = pick_tx(ctl_reg);
  assign go       = state_reg == ST_IDLE && pk[3] && !rx_acc;

  generate
    for (genvar g = 0; g < NTX; g++) begin : g_dir
      assign buf_is_tx[g] = ctl_reg[g].txen;
    end
  endgenerate

  // Write address and data are taken independently
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg  <= RST_16;
      w_strb_reg  <= 2'h0;
    end else begin
      if (awvalid && !aw_full_reg) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= awaddr;
      end else if (wr_en) begin
        aw_full_reg <= 1'b0;
      end
      if (wvalid && !w_full_reg) begin
        w_full_reg <= 1'b1;
        w_data_reg <= wdata[15:0];
        w_strb_reg <= wstrb[1:0];
      end else if (wr_en) begin
        w_full_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (wr_en) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wdec[4] ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= RESP_OKAY;
      rdata_reg  <= 32'h0000_0000;
    end else if (arvalid && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= rdec[4] ? RESP_OKAY : RESP_SLVERR;
      rdata_reg  <= 32'h0000_0000;
      // Unmapped and misaligned reads return zero
      if (!rdec[4])
        rdata_reg[15:0] <= RST_16;
      else if (rdec[3:0] < A_FUL_LO[5:2])
        rdata_reg[15:0] <= mask_reg[rdec[1:0]];
      else if (rdec[3:0] == A_FUL_LO[5:2])
        rdata_reg[15:0] <= full_reg[15:0];
      else if (rdec[3:0] == A_FUL_HI[5:2])
        rdata_reg[15:0] <= full_reg[31:16];
      else if (rdec[3:0] == A_OVF_LO[5:2])
        rdata_reg[15:0] <= ovf_reg[15:0];
      else if (rdec[3:0] == A_OVF_HI[5:2])
        rdata_reg[15:0] <= ovf_reg[31:16];
      else if (rdec[3:0] < A_BASE[5:2])
        rdata_reg[15:0] <= {ctl_reg[2'(rdec[3:0] - A_CTL0[5:2]) * 2 + 1],
                            ctl_reg[2'(rdec[3:0] - A_CTL0[5:2]) * 2]};
      else
        rdata_reg[15:0] <= base_reg;
    end else if (rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NMASK; i++)
        mask_reg[i] <= RST_16;
      base_reg <= '0;
    end else if (wr_en && wdec[4]) begin
      if (wdec[3:0] < A_FUL_LO[5:2])
        mask_reg[wdec[1:0]] <= (mask_reg[wdec[1:0]] & ~wmask) | (w_data_reg & wmask);
      else if (wdec[3:0] == A_BASE[5:2])
        base_reg <= (base_reg & ~wmask) | (w_data_reg & wmask);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      match_reg <= 1'b0;
    else
      match_reg <= acc_mask_sel != MSEL_RSVD &&
                   ((acc_msg_eid ^ acc_filt_eid) & mask_reg[acc_mask_sel]) == RST_16;
  end

  // A store in the same cycle as a clear wins
  always_comb begin
    full_next = full_reg;
    ovf_next  = ovf_reg;
    if (wr_en && wdec[4] && wdec[3:0] == A_FUL_LO[5:2]) full_next[15:0]  = full_reg[15:0] & ~clr16;
    if (wr_en && wdec[4] && wdec[3:0] == A_FUL_HI[5:2]) full_next[31:16] = full_reg[31:16] & ~clr16;
    if (wr_en && wdec[4] && wdec[3:0] == A_OVF_LO[5:2]) ovf_next[15:0]   = ovf_reg[15:0] & ~clr16;
    if (wr_en && wdec[4] && wdec[3:0] == A_OVF_HI[5:2]) ovf_next[31:16]  = ovf_reg[31:16] & ~clr16;
    if (rx_acc) begin
      if (full_reg[rx_store_buf])
        ovf_next[rx_store_buf] = 1'b1;
      else
        full_next[rx_store_buf] = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      full_reg <= '0;
      ovf_reg  <= '0;
    end else begin
      full_reg <= full_next;
      ovf_reg  <= ovf_next;
    end
  end

  always_comb begin
    cbtc_ctl_t wb;
    wb         = '0;
    abort_next = 1'b0;
    cancel     = 1'b0;
    for (int i = 0; i < NTX; i++) begin
      ctl_next[i] = ctl_reg[i];
      wb = w_data_reg[(i % 2) * 8 +: 8];
      if (ctl_wr && ctl_pair == 2'(i / 2) && w_strb_reg[i % 2]) begin
        ctl_next[i].txen  = wb.txen;
        ctl_next[i].rtren = wb.rtren;
        ctl_next[i].pri   = wb.pri;
        if (wb.req && !ctl_reg[i].req) begin
          ctl_next[i].req  = 1'b1;
          ctl_next[i].abt  = 1'b0;
          ctl_next[i].larb = 1'b0;
          ctl_next[i].err  = 1'b0;
        end else if (!wb.req && ctl_reg[i].req) begin
          // A frame already on the bus is stopped by the engine
          if (state_reg == ST_BUSY && act_reg == 3'(i)) begin
            abort_next = 1'b1;
          end else begin
            ctl_next[i].req = 1'b0;
            ctl_next[i].abt = 1'b1;
            cancel = cancel || (state_reg != ST_IDLE && act_reg == 3'(i)) || (go && pk[2:0] == 3'(i));
          end
        end
      end
      if (rtr_rx_valid && rtr_rx_buf == 3'(i) && ctl_reg[i].txen && ctl_reg[i].rtren) begin
        ctl_next[i].req  = 1'b1;
        ctl_next[i].abt  = 1'b0;
        ctl_next[i].larb = 1'b0;
        ctl_next[i].err  = 1'b0;
      end
      if (state_reg == ST_BUSY && act_reg == 3'(i)) begin
        if (tx_ok) begin
          ctl_next[i].req = 1'b0;
          ctl_next[i].abt = 1'b0;
        end
        if (tx_lost_arb) ctl_next[i].larb = 1'b1;
        if (tx_bus_err)  ctl_next[i].err  = 1'b1;
        if (tx_aborted) begin
          ctl_next[i].req = 1'b0;
          ctl_next[i].abt = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NTX; i++)
        ctl_reg[i] <= '0;
      abort_reg <= 1'b0;
    end else begin
      for (int i = 0; i < NTX; i++)
        ctl_reg[i] <= ctl_next[i];
      abort_reg <= abort_next;
    end
  end

  // Lost arbitration or bus error returns to idle; the request stays for a retry
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg    <= ST_IDLE;
      act_reg      <= 3'h0;
      tx_start_reg <= 1'b0;
      hdr_reg      <= '0;
    end else begin
      tx_start_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (go && !cancel) begin
            act_reg   <= pk[2:0];
            state_reg <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          state_reg <= cancel ? ST_IDLE : ST_WAIT;
        end
        ST_WAIT: begin
          if (cancel) begin
            state_reg <= ST_IDLE;
          end else begin
            hdr_reg.buf_id <= act_reg;
            hdr_reg.sid    <= mem_rdata[W0_SID_HI:W0_SID_LO];
            hdr_reg.ext    <= mem_rdata[W0_IDE];
            hdr_reg.rtr    <= !mem_rdata[W0_IDE] && mem_rdata[W0_SRR];
            tx_start_reg   <= 1'b1;
            state_reg      <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          if (tx_ok || tx_aborted || tx_lost_arb || tx_bus_err)
            state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem_addr_reg  <= '0;
      mem_rd_reg    <= 1'b0;
      mem_wr_reg    <= 1'b0;
      mem_wdata_reg <= RST_16;
    end else begin
      mem_rd_reg <= go;
      mem_wr_reg <= rx_acc;
      if (rx_acc) begin
        mem_addr_reg  <= buf_addr(base_reg, rx_store_buf, WORD7);
        mem_wdata_reg <= 16'({rx_store_filter, W7_FIL_LO'(0)});
      end else if (go) begin
        mem_addr_reg <= buf_addr(base_reg, {2'h0, pk[2:0]}, WORD0);
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_word7;
    mem_wr_reg && 3'(mem_addr_reg - base_reg) == WORD7;
  endsequence
  sequence s_pick;
    go && !cancel ##1 !cancel ##1 !cancel;
  endsequence

  full_set_a: assert property (rx_acc && !full_reg[rx_store_buf] |=> full_reg[$past(rx_store_buf)])
    else $error("full flag not set on store");
  ovf_set_a: assert property (rx_acc && full_reg[rx_store_buf] |=> ovf_reg[$past(rx_store_buf)])
    else $error("overflow flag not set on store into full buffer");
  flag_hold_a: assert property (!$past(wr_en) |-> (ovf_reg & $past(ovf_reg)) == $past(ovf_reg))
    else $error("overflow flag dropped without a write");
  mask_match_a: assert property (acc_mask_sel == 2'h0 && ((acc_msg_eid ^ acc_filt_eid) & mask_reg[0]) != RST_16
                                 |=> !acc_eid_match)
    else $error("masked mismatch reported as match");
  status_clear_a: assert property ($rose(ctl_reg[0].req) |-> !ctl_reg[0].abt && !ctl_reg[0].larb && !ctl_reg[0].err)
    else $error("status left set when send request rose");
  done_clear_a: assert property (state_reg == ST_BUSY && tx_ok |=> !ctl_reg[act_reg].req && !ctl_reg[act_reg].abt)
    else $error("send request not cleared after success");
  abort_req_a: assert property (abort_next |=> tx_abort_req ##1 !tx_abort_req)
    else $error("abort request not a single pulse");
  rtr_set_a: assert property (rtr_rx_valid && ctl_reg[rtr_rx_buf].txen && ctl_reg[rtr_rx_buf].rtren &&
                              !(state_reg == ST_BUSY && act_reg == rtr_rx_buf)
                              |=> ctl_reg[$past(rtr_rx_buf)].req)
    else $error("remote request did not set send request");
  fetch_seq_a: assert property (tx_start_reg |-> $past(mem_rd_reg, 2) && tx_hdr.ext == $past(mem_rdata[W0_IDE]))
    else $error("frame started without a word 0 fetch");
  hdr_fetch_a: assert property (s_pick |=> tx_start_reg && $past(mem_rd_reg, 2))
    else $error("fetch did not start a frame");
  word7_a: assert property (rx_acc |=> s_word7 ##0 mem_wdata[12:8] == $past(rx_store_filter))
    else $error("filter number not written to word 7");
endmodule

// File: tb/cbtc_can_model.sv
`timescale 1ns/1ps
module cbtc_can_model (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic [cbtc_pkg::MEM_AW-1:0] mem_addr,
  input  wire logic                    mem_rd,
  input  wire logic                    mem_wr,
  input  wire logic [15:0]             mem_wdata,
  output logic      [15:0]             mem_rdata,
  input  wire logic                    tx_start,
  input  wire logic                    tx_abort_req,
  input  wire logic [1:0]              outc,
  input  wire logic [7:0]              dly,
  output logic                         tx_ok,
  output logic                         tx_lost_arb,
  output logic                         tx_bus_err,
  output logic                         tx_aborted
);
  import cbtc_pkg::*;
  logic [15:0] ram [0:2**MEM_AW-1];
  logic [7:0]  cnt;
  logic [1:0]  res;
  logic        busy;

  // Read data is only valid the cycle after a read; otherwise it toggles
  always @(posedge aclk) begin
    if (mem_wr) ram[mem_addr] <= mem_wdata;
    if (!aresetn)
      mem_rdata <= 16'h0000;
    else
      mem_rdata <= mem_rd ? ram[mem_addr] : ~mem_rdata;
  end

  // Outcome chosen at frame start, answered after dly cycles or on abort
  always @(posedge aclk) begin
    {tx_ok, tx_lost_arb, tx_bus_err, tx_aborted} <= 4'h0;
    if (!aresetn) begin
      busy <= 1'b0;
    end else if (tx_start) begin
      busy <= 1'b1;
      cnt <= dly;
      res <= outc;
    end else if (busy && (tx_abort_req || cnt == 8'h00)) begin
      busy <= 1'b0;
      if (tx_abort_req) tx_aborted <= 1'b1;
      else if (res == 2'h1) tx_lost_arb <= 1'b1;
      else if (res == 2'h2) tx_bus_err <= 1'b1;
      else tx_ok <= 1'b1;
    end else begin
      cnt <= cnt - 8'h01;
    end
  end
endmodule

// File: tb/cbtc_top_tb.sv
`timescale 1ns/1ps
module cbtc_top_tb;
  import cbtc_pkg::*;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, acc_eid_match, mem_rd, mem_wr;
  logic        rx_store_valid, rtr_rx_valid, tx_ok, tx_lost_arb, tx_bus_err, tx_aborted;
  logic        tx_start, tx_abort_req;
  logic [7:0]  awaddr, araddr, buf_is_tx, dly;
  logic [31:0] wdata, rdata, rnd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, acc_mask_sel, outc;
  logic [4:0]  rx_store_buf, rx_store_filter;
  logic [2:0]  rtr_rx_buf;
  logic [15:0] acc_msg_eid, acc_filt_eid, mem_addr, mem_wdata, mem_rdata, dif;
  logic [15:0] msk [4];
  logic [33:0] exp_q[$], hdr_q[$];
  cbtc_txhdr_t tx_hdr;
  int          num_errors = 0;
  int          compares = 0;

  cbtc_top dut_u (.*);
  cbtc_can_model cmod_u (.*);

  always #2.5 aclk = ~aclk;

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  function automatic logic [33:0] hdr(input logic [2:0] b);
    return {18'h0, b, b, 8'h35, b == 3'h4, b == 3'h1};
  endfunction

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] e = RESP_OKAY);
    logic ta, td;
    ta = 1'b0;
    td = 1'b0;
    exp_q.push_back({e, 32'h0});
    awaddr <= a;
    wdata <= {16'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ta && td)) begin
      @(posedge aclk);
      if (!ta && awready) begin
        ta = 1'b1;
        awvalid <= 1'b0;
      end
      if (!td && wready) begin
        td = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] d, input logic [1:0] e = RESP_OKAY);
    exp_q.push_back({e, 16'h0, d});
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
  endtask

  task automatic rxs(input logic [4:0] b, input logic [4:0] f);
    rx_store_buf <= b;
    rx_store_filter <= f;
    rx_store_valid <= 1'b1;
    @(posedge aclk);
    rx_store_valid <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask

  task automatic rtr(input logic [2:0] b);
    rtr_rx_buf <= b;
    rtr_rx_valid <= 1'b1;
    @(posedge aclk);
    rtr_rx_valid <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask

  task automatic wait_start();
    do @(posedge aclk); while (!tx_start);
  endtask

  // Monitor: every answer takes the oldest expectation
  always @(posedge aclk) begin
    if (rvalid && rready) chk({rresp, rdata}, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
    if (bvalid && bready) chk({bresp, 32'h0}, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
    if (tx_start) chk(34'(tx_hdr), hdr_q.size() > 0 ? hdr_q.pop_front() : 'x);
  end

  initial begin
    #60us;
    num_errors++;
    $display("ERROR %0t watchdog expired", $time);
    wrap_up();
  end

  initial begin
    {aclk, aresetn, awvalid, wvalid, arvalid, rx_store_valid, rtr_rx_valid} = '0;
    {bready, rready, wstrb} = 6'h3f;
    {awaddr, araddr, wdata, rx_store_buf, rx_store_filter, rtr_rx_buf} = '0;
    {acc_mask_sel, acc_msg_eid, acc_filt_eid, outc} = '0;
    dly = 8'd4;
    rnd = 32'h18;
    msk[3] = 16'h0;
    for (int b = 0; b < 8; b++) cmod_u.ram[16'h100 + 16'(b * 8)] = {3'h0, 3'(b), 8'h35, b == 1 || b == 4, b == 4};
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int a = 12; a <= 40; a += 4) rd(8'(a), 16'h0);
    rd(8'h30, 16'h0, RESP_SLVERR);
    rd(8'h0e, 16'h0, RESP_SLVERR);
    wr(8'h30, 16'hffff, RESP_SLVERR);
    wr(A_BASE, 16'h0100);
    rd(A_BASE, 16'h0100);
    for (int m = 0; m < 3; m++) begin
      rnd = xs(rnd);
      msk[m] = rnd[15:0];
      wr(8'(4 * m), msk[m]);
      rd(8'(4 * m), msk[m]);
    end
    for (int i = 0; i < 32; i++) begin
      rnd = xs(rnd);
      dif = rnd[31] ? rnd[15:0] & ~msk[rnd[1:0]] : rnd[15:0];
      acc_mask_sel <= rnd[1:0];
      acc_msg_eid <= rnd[31:16];
      acc_filt_eid <= rnd[31:16] ^ dif;
      repeat (2) @(posedge aclk);
      chk(34'(acc_eid_match), 34'(rnd[1:0] != MSEL_RSVD && (dif & msk[rnd[1:0]]) == 16'h0));
    end
    rxs(5'd20, 5'd5);
    rd(A_FUL_HI, 16'h0010);
    chk(34'(cmod_u.ram[16'h01a7]), 34'(16'h0500));
    rxs(5'd20, 5'd9);
    rd(A_OVF_HI, 16'h0010);
    wr(A_FUL_HI, 16'hffff);
    rd(A_FUL_HI, 16'h0010);
    wr(A_OVF_HI, 16'hffef);
    rd(A_OVF_HI, 16'h0000);
    wr(A_FUL_HI, 16'hffef);
    rd(A_FUL_HI, 16'h0000);
    rxs(5'd3, 5'd1);
    wr(A_CTL0 + 8'h04, 16'h8480);
    rxs(5'd2, 5'd0);
    rd(A_FUL_LO, 16'h0008);
    chk(34'(buf_is_tx), 34'(8'h0c));
    rtr(3'h2);
    rd(A_CTL0 + 8'h04, 16'h8480);
    hdr_q.push_back(hdr(3'h3));
    rtr(3'h3);
    repeat (30) @(posedge aclk);
    rd(A_CTL0 + 8'h04, 16'h8480);
    dly <= 8'd30;
    hdr_q.push_back(hdr(3'h7));
    hdr_q.push_back(hdr(3'h4));
    hdr_q.push_back(hdr(3'h1));
    hdr_q.push_back(hdr(3'h0));
    hdr_q.push_back(hdr(3'h6));
    wr(A_CTL0 + 8'h0c, 16'h8988);
    wr(A_CTL0, 16'h8a8a);
    wr(A_CTL0 + 8'h08, 16'h808b);
    repeat (250) @(posedge aclk);
    rd(A_CTL0, 16'h8282);
    rd(A_CTL0 + 8'h08, 16'h8083);
    rd(A_CTL0 + 8'h0c, 16'h8180);
    dly <= 8'd4;
    outc <= 2'h1;
    repeat (3) hdr_q.push_back(hdr(3'h6));
    wr(A_CTL0 + 8'h0c, 16'h8188);
    wait_start();
    outc <= 2'h2;
    wait_start();
    outc <= 2'h0;
    wait_start();
    repeat (20) @(posedge aclk);
    rd(A_CTL0 + 8'h0c, 16'h81b0);
    dly <= 8'd60;
    hdr_q.push_back(hdr(3'h6));
    wr(A_CTL0 + 8'h0c, 16'h8188);
    wait_start();
    rd(A_CTL0 + 8'h0c, 16'h8188);
    wr(A_CTL0 + 8'h0c, 16'h8180);
    repeat (10) @(posedge aclk);
    rd(A_CTL0 + 8'h0c, 16'h81c0);
    repeat (5) @(posedge aclk);
    chk(34'(exp_q.size() + hdr_q.size()), 34'h0);
    wrap_up();
  end
endmodule
